// ===== include/mii_port_defs.svh
// Purpose: shared constants of the media-independent port block
// Assumes: included by its bare name, once per compilation unit
// Notes: counts are in link clock nibble times unless said otherwise
`ifndef MII_PORT_DEFS_SVH
`define MII_PORT_DEFS_SVH

`define MII_NIBBLE_W 4
`define MII_FIFO_DEPTH 16
`define MII_SYNC_STAGES 2
// idle nibble times between two frames (96 bit times)
`define MII_GAP_NIBBLES 24
`define MII_GAP_W 5
// link clock rates supplied by the phy
`define MII_LINK_FAST_KHZ 25000
`define MII_LINK_SLOW_KHZ 2500

`endif

// ===== include/mii_port_pkg.sv
// Purpose: types carried between the port block, its fifos and the user side
// Assumes: mii_port_defs.svh supplies the widths
// Notes: none
`include "mii_port_defs.svh"

package mii_port_pkg;

  // one transmit nibble; last closes the frame
  typedef struct packed {
    logic last;
    logic [`MII_NIBBLE_W-1:0] nibble;
  } tx_word_t;

  // one received nibble; first opens a frame
  typedef struct packed {
    logic first;
    logic [`MII_NIBBLE_W-1:0] nibble;
  } rx_word_t;

  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_GAP} tx_state_t;

endpackage

// ===== logic/cdc_fifo.sv
// Purpose: dual-clock fifo with gray-coded pointers
// Assumes: DEPTH is a power of two; each side has its own synchronous reset
// Notes: storage is flip-flops; pointers cross through two flops each
`timescale 1ns/10ps
`default_nettype none

module cdc_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  // write side
  input wire logic wr_clk,
  input wire logic wr_rst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic rd_clk,
  input wire logic rd_rst_n,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_bin, rd_bin, wr_gray, rd_gray;
  logic [AW:0] rd_gray_meta, rd_gray_sync, wr_gray_meta, wr_gray_sync;
  wire [AW:0] next_wr_bin = wr_bin + (AW+1)'(wr_valid && wr_ready);
  wire [AW:0] next_rd_bin = rd_bin + (AW+1)'(rd_valid && rd_ready);
  wire [AW:0] full_gray = {~rd_gray_sync[AW:AW-1], rd_gray_sync[AW-2:0]};

  assign wr_ready = (wr_gray != full_gray);
  assign rd_valid = (rd_gray != wr_gray_sync);
  assign rd_data = mem[rd_bin[AW-1:0]];

  always_ff @(posedge wr_clk)
  begin
    if (wr_valid && wr_ready)
      mem[wr_bin[AW-1:0]] <= wr_data;
  end

  always_ff @(posedge wr_clk)
  begin
    if (!wr_rst_n)
    begin
      wr_bin <= '0;
      wr_gray <= '0;
      rd_gray_meta <= '0;
      rd_gray_sync <= '0;
    end
    else
    begin
      wr_bin <= next_wr_bin;
      wr_gray <= next_wr_bin ^ (next_wr_bin >> 1);
      rd_gray_meta <= rd_gray;
      rd_gray_sync <= rd_gray_meta;
    end
  end

  always_ff @(posedge rd_clk)
  begin
    if (!rd_rst_n)
    begin
      rd_bin <= '0;
      rd_gray <= '0;
      wr_gray_meta <= '0;
      wr_gray_sync <= '0;
    end
    else
    begin
      rd_bin <= next_rd_bin;
      rd_gray <= next_rd_bin ^ (next_rd_bin >> 1);
      wr_gray_meta <= wr_gray;
      wr_gray_sync <= wr_gray_meta;
    end
  end

endmodule
`default_nettype wire

// ===== logic/mii_port.sv
// Purpose: second media-independent port, pin side toward an ethernet phy
// Assumes: phy supplies both link clocks; user side runs on clk at 20 MHz
// Notes: transmit and receive nibbles cross through dual-clock fifos
//
// Contract
// - transmit nibbles are driven on the phy-supplied transmit clock.
// - transmit enable rises with first preamble nibble, holds until frame ends.
// - receive nibbles are sampled on the phy-supplied receive clock.
// - receive nibbles count as frame data only while receive valid is high.
// - carrier sense may rise asynchronously; the block tolerates that edge.
`timescale 1ns/10ps
`default_nettype none
`include "mii_port_defs.svh"

module mii_port #(
  parameter int DEPTH = `MII_FIFO_DEPTH,
  parameter int GAP_NIBBLES = `MII_GAP_NIBBLES
) (
  // system side
  input wire logic clk,
  input wire logic rst_n,
  // transmit stream in
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  input wire mii_port_pkg::tx_word_t tx_in_word,
  // receive stream out
  output logic rx_out_valid,
  input wire logic rx_out_ready,
  output mii_port_pkg::rx_word_t rx_out_word,
  // status toward the mac
  output logic carrier_sense,
  output logic collision,
  output logic tx_underrun,
  output logic rx_overrun,
  // phy transmit pins
  input wire logic port_tx_clock_in,
  output logic [`MII_NIBBLE_W-1:0] port_tx_nibble,
  output logic port_tx_enable,
  // phy receive pins
  input wire logic port_rx_clock_in,
  input wire logic [`MII_NIBBLE_W-1:0] port_rx_nibble,
  input wire logic port_rx_valid,
  input wire logic port_collision_in,
  input wire logic port_carrier_sense_in
);
  import mii_port_pkg::*;

  localparam int WW = `MII_NIBBLE_W + 1;
  localparam logic [`MII_GAP_W-1:0] GAP_LAST = `MII_GAP_W'(GAP_NIBBLES - 1);

  // reset carried into each link domain
  logic tx_rst_meta, tx_rst_n, rx_rst_meta, rx_rst_n;

  // transmit domain
  tx_state_t tx_state, next_tx_state;
  tx_word_t tx_rd_word;
  logic tx_rd_valid;
  logic tx_pop;
  logic [`MII_GAP_W-1:0] tx_gap_count;
  logic tx_under_toggle;

  // receive domain
  rx_word_t rx_push_word;
  logic rx_push_ready;
  logic rx_prev_valid;
  logic rx_over_toggle;

  // system domain crossings
  logic crs_meta, crs_sync, col_meta, col_sync;
  logic under_meta, under_sync, under_seen;
  logic over_meta, over_sync, over_seen;

  // the link clocks stop when the phy is absent; reset reaches them late then
  always_ff @(posedge port_tx_clock_in)
  begin
    tx_rst_meta <= rst_n;
    tx_rst_n <= tx_rst_meta;
  end

  always_ff @(posedge port_rx_clock_in)
  begin
    rx_rst_meta <= rst_n;
    rx_rst_n <= rx_rst_meta;
  end

  // transmit path
  cdc_fifo #(
    .WIDTH(WW),
    .DEPTH(DEPTH)
  ) tx_fifo (
    .wr_clk(clk),
    .wr_rst_n(rst_n),
    .wr_valid(tx_in_valid),
    .wr_ready(tx_in_ready),
    .wr_data(tx_in_word),
    .rd_clk(port_tx_clock_in),
    .rd_rst_n(tx_rst_n),
    .rd_valid(tx_rd_valid),
    .rd_ready(tx_pop),
    .rd_data(tx_rd_word)
  );

  // a frame is taken one nibble per transmit clock once its first word is in
  assign tx_pop = tx_rd_valid && (tx_state != TX_GAP);
  wire tx_starve = (tx_state == TX_SEND) && !tx_rd_valid;
  wire tx_gap_done = (tx_gap_count == GAP_LAST);

  always_comb
  begin
    next_tx_state = tx_state;
    unique case (tx_state)
      TX_IDLE:
        if (tx_pop)
          next_tx_state = tx_rd_word.last ? TX_GAP : TX_SEND;
      TX_SEND:
        if (tx_starve || (tx_pop && tx_rd_word.last))
          next_tx_state = TX_GAP;
      TX_GAP:
        if (tx_gap_done)
          next_tx_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge port_tx_clock_in)
  begin
    if (!tx_rst_n)
    begin
      tx_state <= TX_IDLE;
      tx_gap_count <= '0;
      tx_under_toggle <= 1'b0;
    end
    else
    begin
      tx_state <= next_tx_state;
      tx_gap_count <= (tx_state == TX_GAP) ? tx_gap_count + 1'b1 : '0;
      if (tx_starve)
        tx_under_toggle <= ~tx_under_toggle;
    end
  end

  // pins change only on the transmit clock; enable follows each pop
  always_ff @(posedge port_tx_clock_in)
  begin
    if (!tx_rst_n)
    begin
      port_tx_enable <= 1'b0;
      port_tx_nibble <= '0;
    end
    else
    begin
      port_tx_enable <= tx_pop;
      port_tx_nibble <= tx_pop ? tx_rd_word.nibble : '0;
    end
  end

  // receive path: the phy cannot be stalled, so a full fifo drops nibbles
  assign rx_push_word.first = port_rx_valid && !rx_prev_valid;
  assign rx_push_word.nibble = port_rx_nibble;
  wire rx_push = port_rx_valid;
  wire rx_drop = rx_push && !rx_push_ready;

  cdc_fifo #(
    .WIDTH(WW),
    .DEPTH(DEPTH)
  ) rx_fifo (
    .wr_clk(port_rx_clock_in),
    .wr_rst_n(rx_rst_n),
    .wr_valid(rx_push),
    .wr_ready(rx_push_ready),
    .wr_data(rx_push_word),
    .rd_clk(clk),
    .rd_rst_n(rst_n),
    .rd_valid(rx_out_valid),
    .rd_ready(rx_out_ready),
    .rd_data(rx_out_word)
  );

  always_ff @(posedge port_rx_clock_in)
  begin
    if (!rx_rst_n)
    begin
      rx_prev_valid <= 1'b0;
      rx_over_toggle <= 1'b0;
    end
    else
    begin
      rx_prev_valid <= port_rx_valid;
      if (rx_drop)
        rx_over_toggle <= ~rx_over_toggle;
    end
  end

  // carrier sense may rise with no clock at all, so both status pins are
  // taken in on clk through two flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      crs_meta <= 1'b0;
      crs_sync <= 1'b0;
      col_meta <= 1'b0;
      col_sync <= 1'b0;
    end
    else
    begin
      crs_meta <= port_carrier_sense_in;
      crs_sync <= crs_meta;
      col_meta <= port_collision_in;
      col_sync <= col_meta;
    end
  end

  assign carrier_sense = crs_sync;
  assign collision = col_sync;

  // error toggles become one-cycle pulses on clk
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      under_meta <= 1'b0;
      under_sync <= 1'b0;
      under_seen <= 1'b0;
      over_meta <= 1'b0;
      over_sync <= 1'b0;
      over_seen <= 1'b0;
    end
    else
    begin
      under_meta <= tx_under_toggle;
      under_sync <= under_meta;
      under_seen <= under_sync;
      over_meta <= rx_over_toggle;
      over_sync <= over_meta;
      over_seen <= over_sync;
    end
  end

  assign tx_underrun = under_sync ^ under_seen;
  assign rx_overrun = over_sync ^ over_seen;

  // checks in the transmit domain
  sequence s_tx_last_pop;
    tx_pop && tx_rd_word.last;
  endsequence

  sequence s_tx_quiet;
    !port_tx_enable ##1 !port_tx_enable;
  endsequence

  a_tx_nibble_drive: assert property (
    @(posedge port_tx_clock_in) disable iff (!tx_rst_n)
    tx_pop |=> (port_tx_nibble == $past(tx_rd_word.nibble)) && port_tx_enable)
    else $error("transmit nibble not driven from popped word");

  a_tx_enable_hold: assert property (
    @(posedge port_tx_clock_in) disable iff (!tx_rst_n)
    (tx_state == TX_SEND) && tx_rd_valid |=> port_tx_enable)
    else $error("transmit enable dropped inside a frame");

  a_tx_enable_rise: assert property (
    @(posedge port_tx_clock_in) disable iff (!tx_rst_n)
    $rose(port_tx_enable) |-> $past(tx_state) == TX_IDLE)
    else $error("transmit enable rose outside frame start");

  a_tx_frame_end: assert property (
    @(posedge port_tx_clock_in) disable iff (!tx_rst_n)
    s_tx_last_pop |=> port_tx_enable ##1 s_tx_quiet)
    else $error("transmit enable not released after last nibble");

  a_tx_idle_quiet: assert property (
    @(posedge port_tx_clock_in) disable iff (!tx_rst_n)
    !tx_pop |=> !port_tx_enable && (port_tx_nibble == '0))
    else $error("transmit pins not idle between frames");

  // checks in the receive domain
  a_rx_valid_gate: assert property (
    @(posedge port_rx_clock_in) disable iff (!rx_rst_n)
    !port_rx_valid |=> $stable(rx_fifo.wr_bin))
    else $error("receive nibble taken without receive valid");

  a_rx_first_mark: assert property (
    @(posedge port_rx_clock_in) disable iff (!rx_rst_n)
    $rose(port_rx_valid) |-> rx_push_word.first && (rx_push_word.nibble == port_rx_nibble))
    else $error("first receive nibble not marked");

  // checks in the system domain
  a_crs_sync_delay: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n, 2) && $past(rst_n) |-> carrier_sense == $past(port_carrier_sense_in, 2))
    else $error("carrier sense not delayed by two flops");

  a_col_sync_delay: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(port_collision_in) && rst_n ##1 port_collision_in |-> ##1 collision)
    else $error("collision not seen two edges after rising");

endmodule
`default_nettype wire

// ===== sim/phy_model.sv
// Purpose: behavioural phy at the far side of the media-independent port
// Assumes: link clocks run free at 64 ns, out of phase with clk
// Notes: idle receive nibbles show the inverse of the last one sent
`timescale 1ns/10ps
`default_nettype none

module phy_model (
  // link clocks
  output logic tx_clk,
  output logic rx_clk,
  // transmit pins
  input wire logic [3:0] tx_nibble,
  input wire logic tx_enable,
  // receive and status pins
  output logic [3:0] rx_nibble,
  output logic rx_valid,
  output logic col,
  output logic crs
);
  logic [3:0] got[$];
  int frames = 0;
  logic was_en = 1'b0;

  // fractional offsets keep link edges off the clk edges
  initial
  begin
    tx_clk = 1'b0;
    #7.1;
    forever #32 tx_clk = ~tx_clk;
  end

  initial
  begin
    rx_clk = 1'b0;
    rx_nibble = 4'h0;
    rx_valid = 1'b0;
    col = 1'b0;
    crs = 1'b0;
    #3.3;
    forever #32 rx_clk = ~rx_clk;
  end

  always @(posedge tx_clk)
  begin
    if (tx_enable)
      got.push_back(tx_nibble);
    if (tx_enable && !was_en)
      frames++;
    was_en = tx_enable;
  end

  task automatic send(input logic [3:0] q[$]);
    #5 crs = 1'b1;
    foreach (q[i])
    begin
      @(posedge rx_clk);
      rx_valid <= 1'b1;
      rx_nibble <= q[i];
    end
    @(posedge rx_clk);
    rx_valid <= 1'b0;
    rx_nibble <= ~q[q.size()-1];
    crs <= 1'b0;
  endtask

  task automatic collide(input int n);
    @(posedge rx_clk);
    crs <= 1'b1;
    col <= 1'b1;
    repeat (n) @(posedge rx_clk);
    col <= 1'b0;
    @(posedge rx_clk);
    crs <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ===== sim/test_mii_port_pin_behaviour.sv
// Purpose: self-checking bench of the media-independent port
// Assumes: phy_model drives both link clocks and the receive pins
// Notes: gap shortened to 2 nibble times to keep the run short
`timescale 1ns/10ps
`default_nettype none

module test_mii_port_pin_behaviour;
  import mii_port_pkg::*;
  logic clk, rst_n, tx_in_valid, tx_in_ready, rx_out_valid, rx_out_ready;
  tx_word_t tx_in_word;
  rx_word_t rx_out_word;
  logic carrier_sense, collision, tx_underrun, rx_overrun;
  logic tx_clk, rx_clk, tx_en, rx_valid, col, crs;
  logic [3:0] tx_nib, rx_nib;
  logic [1:0] h_col = 2'h0;
  logic [1:0] h_crs = 2'h0;
  logic [4:0] exp_rx[$];
  int errors = 0;
  int check_count = 0;
  int live = 0;
  int ovr = 0;
  int und = 0;
  int fr = 0;

  mii_port #(.DEPTH(16), .GAP_NIBBLES(2)) mii_port_inst (
    .clk(clk), .rst_n(rst_n), .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready),
    .tx_in_word(tx_in_word), .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
    .rx_out_word(rx_out_word), .carrier_sense(carrier_sense), .collision(collision),
    .tx_underrun(tx_underrun), .rx_overrun(rx_overrun), .port_tx_clock_in(tx_clk),
    .port_tx_nibble(tx_nib), .port_tx_enable(tx_en), .port_rx_clock_in(rx_clk),
    .port_rx_nibble(rx_nib), .port_rx_valid(rx_valid), .port_collision_in(col),
    .port_carrier_sense_in(crs));

  phy_model phy_model_inst (.tx_clk(tx_clk), .rx_clk(rx_clk), .tx_nibble(tx_nib),
    .tx_enable(tx_en), .rx_nibble(rx_nib), .rx_valid(rx_valid), .col(col), .crs(crs));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic guard(input int k);
    if (k > 3000)
    begin
      errors++;
      $display("wrong value wait expected done seen timeout");
      stop_test();
    end
  endtask

  task automatic tx_frame(input int len);
    logic [3:0] q[$];
    int k;
    for (int i = 0; i < len; i++)
      q.push_back(4'($urandom));
    phy_model_inst.got = {};
    fr++;
    foreach (q[i])
    begin
      tx_in_valid <= 1'b1;
      tx_in_word <= '{last: (i == len - 1), nibble: q[i]};
      k = 0;
      do
      begin
        @(posedge clk);
        guard(k++);
      end while (tx_in_ready !== 1'b1);
    end
    tx_in_valid <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clk);
      guard(k++);
    end while (phy_model_inst.got.size() < len || tx_en !== 1'b0);
    check("tx frames", 8'(phy_model_inst.frames), 8'(fr));
    check("tx count", 8'(phy_model_inst.got.size()), 8'(len));
    foreach (q[i])
      check("tx nibble", {4'h0, phy_model_inst.got[i]}, {4'h0, q[i]});
  endtask

  // a frame whose feed stops after one nibble is cut short and flagged
  task automatic tx_cut();
    int k;
    phy_model_inst.got = {};
    tx_in_valid <= 1'b1;
    tx_in_word <= '{last: 1'b0, nibble: 4'hA};
    k = 0;
    do
    begin
      @(posedge clk);
      guard(k++);
    end while (tx_in_ready !== 1'b1);
    tx_in_valid <= 1'b0;
    repeat (40) @(posedge clk);
    check("cut frame", 8'(phy_model_inst.got.size()), 8'h01);
    check("cut nibble", {4'h0, phy_model_inst.got[0]}, 8'h0A);
    check("underrun", 8'(und), 8'h01);
  endtask

  // the user side stalls while the phy sends, so the fifo must absorb it
  task automatic rx_frame(input int len, input int keep);
    logic [3:0] q[$];
    int k;
    for (int i = 0; i < len; i++)
    begin
      q.push_back(4'($urandom));
      if (i < keep)
        exp_rx.push_back({i == 0, q[i]});
    end
    phy_model_inst.send(q);
    @(posedge clk);
    k = 0;
    rx_out_ready <= 1'b1;
    while (exp_rx.size() > 0)
    begin
      @(posedge clk);
      guard(k++);
      if (rx_out_valid === 1'b1)
        check("rx word", {3'h0, rx_out_word}, {3'h0, exp_rx.pop_front()});
    end
    rx_out_ready <= 1'b0;
    repeat (40) @(posedge clk);
    check("rx left", {7'h0, rx_out_valid}, 8'h00);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // collision and carrier sense outputs follow their pins two clk edges late
  always @(posedge clk)
  begin
    if (live > 2)
    begin
      check("collision", {7'h0, collision}, {7'h0, h_col[1]});
      check("carrier", {7'h0, carrier_sense}, {7'h0, h_crs[1]});
    end
    live <= rst_n ? live + 1 : 0;
    h_col <= {h_col[0], col};
    h_crs <= {h_crs[0], crs};
    ovr <= ovr + (rx_overrun === 1'b1);
    und <= und + (tx_underrun === 1'b1);
  end

  initial
  begin
    rst_n = 1'b0;
    tx_in_valid = 1'b0;
    tx_in_word = '0;
    rx_out_ready = 1'b0;
    void'($urandom(32'h475C));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    tx_frame(1);
    tx_frame(16);
    tx_frame(2 + $urandom % 14);
    check("underrun", 8'(und), 8'h00);
    tx_cut();
    $display("test transmit done");
    rx_frame(1, 1);
    rx_frame(2 + $urandom % 14, 16);
    check("no overrun", 8'(ovr), 8'h00);
    rx_frame(20, 16);
    check("overrun", 8'(ovr), 8'h04);
    $display("test receive done");
    phy_model_inst.collide(4);
    repeat (10) @(posedge clk);
    $display("test status done");
    stop_test();
  end
endmodule

`default_nettype wire
